// ===== testbench/doorbell_message_unit_tb.sv
// Self-checking testbench of the doorbell message unit.
`timescale 1ns/1ps
module doorbell_message_unit_tb;
  import doorbell_pkg::*;
  logic clk, reset, regWrite, regRead, regReadValid_ff, txValid_ff, txReady, txDone;
  logic txError, rxValid, doorbellIrq_ff;
  logic [5:0] regAddr;
  logic [31:0] regWriteData, regReadData_ff, rdata;
  logic [15:0] txMessage_ff, target_endpoint_id_ff, rxMessage, sender_endpoint_id;
  logic [7:0] errPattern;
  logic [15:0] msgA[QUEUE_DEPTH+1];
  logic [15:0] idA[QUEUE_DEPTH+1];
  int err_count = 0;
  int n_checks = 0;
  int tries;
  logic [31:0] sentA[16];
  int nSent = 0;

  // Link monitor: at mid-cycle an offer with ready high is taken at the next edge.
  always @(negedge clk) begin
    if (reset === 1'b0 && txValid_ff === 1'b1 && txReady === 1'b1) begin
      sentA[nSent % 16] = {target_endpoint_id_ff, txMessage_ff};
      nSent++;
    end
  end

  doorbell_message_unit i_dut (.clk(clk), .reset(reset), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData),
    .regReadData_ff(regReadData_ff), .regReadValid_ff(regReadValid_ff),
    .txValid_ff(txValid_ff), .txMessage_ff(txMessage_ff),
    .target_endpoint_id_ff(target_endpoint_id_ff), .txReady(txReady), .txDone(txDone),
    .txError(txError), .rxValid(rxValid), .rxMessage(rxMessage),
    .sender_endpoint_id(sender_endpoint_id), .doorbellIrq_ff(doorbellIrq_ff));
  remote_endpoint_model i_far (.clk(clk), .txValid(txValid_ff), .errPattern(errPattern),
    .txReady(txReady), .txDone(txDone), .txError(txError), .rxValid(rxValid),
    .rxMessage(rxMessage), .sender_endpoint_id(sender_endpoint_id));

  // ==========================================================================
  // Clock, watchdog, comparisons and expectations.
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // The tests need a few hundred cycles; the margin covers slow link stalls.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  task automatic conclude();
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic checkBit(string name, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Completion word: valid, error, low target ID bits, payload.
  function automatic logic [31:0] cplWord(logic [15:0] m, logic [15:0] id, logic e);
    return {1'b1, e, id[13:0], m};
  endfunction
  // Received word: the full sender ID above the payload.
  function automatic logic [31:0] rxWord(logic [15:0] m, logic [15:0] id);
    return {id, m};
  endfunction

  // ==========================================================================
  // Register bus tasks: strobe held for exactly one edge.
  task automatic regWr(logic [5:0] a, logic [31:0] d);
    @(posedge clk);
    #1 regWrite = 1;
    regAddr = a;
    regWriteData = d;
    @(posedge clk);
    #1 regWrite = 0;
  endtask
  task automatic regRd(logic [5:0] a);
    @(posedge clk);
    #1 regRead = 1;
    regAddr = a;
    @(posedge clk);
    #1 regRead = 0;
    rdata = regReadData_ff;
    checkBit("read valid", 1'b1, regReadValid_ff);
  endtask
  task automatic waitIrq();
    tries = 0;
    while (doorbellIrq_ff !== 1'b1 && tries < 200) begin
      @(posedge clk);
      #1 tries++;
    end
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(32'hD8065785));
    {reset, regWrite, regRead, regAddr, regWriteData} = '0;
    reset = 1;
    errPattern = 8'($urandom);
    repeat (2) @(posedge clk);
    #1 reset = 0;
    regRd(OFS_IRQ_ENABLE); check("enable reset", 32'h0, rdata);
    regRd(OFS_TX_STATUS_CTRL); check("ctrl reset", 32'h0, rdata);
    regRd(6'h04); check("unmapped", 32'h0, rdata);
    regRd(OFS_RX_POP); check("empty rx", 32'h0, rdata);
    regRd(OFS_CPL_POP); check("empty cpl", 32'h0, rdata);
    regRd(OFS_TX_PUSH); check("tx room", 32'h1, {31'h0, rdata[0]});
    regWr(OFS_IRQ_ENABLE, 32'h6);
    regWr(OFS_TX_STATUS_CTRL, 32'h1);
    regRd(OFS_IRQ_ENABLE); check("enable", 32'h6, rdata);
    regRd(OFS_TX_STATUS_CTRL); check("ctrl", 32'h1, rdata);
    // Eight back-to-back pushes; every completion comes back in order.
    for (int i = 0; i < 8; i++) begin
      msgA[i] = 16'($urandom);
      idA[i] = 16'($urandom);
      regWr(OFS_TX_PUSH, {idA[i], msgA[i]});
    end
    waitIrq(); checkBit("cpl irq", 1'b1, doorbellIrq_ff);
    for (int i = 0; i < 8; i++) begin
      tries = 0;
      do begin
        regRd(OFS_CPL_POP);
        tries++;
      end while (rdata[31] !== 1'b1 && tries < 100);
      check("completion", cplWord(msgA[i], idA[i], errPattern[i]), rdata);
    end
    for (int i = 0; i < 8; i++) begin
      check("sent packet", {idA[i], msgA[i]}, sentA[i]);
    end
    check("sent count", 32'h0000_0008, nSent);
    repeat (3) @(posedge clk);
    #1 checkBit("cpl irq drained", 1'b0, doorbellIrq_ff);
    // Failures are not recorded once only successes are kept.
    errPattern = 8'hFF;
    regWr(OFS_TX_STATUS_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) regWr(OFS_TX_PUSH, $urandom);
    tries = 0;
    while (nSent < 11 && tries < 200) begin
      @(posedge clk);
      tries++;
    end
    repeat (10) @(posedge clk);
    #1 checkBit("fail irq", 1'b0, doorbellIrq_ff);
    check("sent count", 32'h0000_000B, nSent);
    regRd(OFS_CPL_POP); check("fail dropped", 32'h0, rdata);
    // Receive one doorbell past the depth while the source is masked.
    for (int i = 0; i <= QUEUE_DEPTH; i++) begin
      msgA[i] = 16'($urandom);
      idA[i] = 16'($urandom);
      i_far.sendRx(msgA[i], idA[i]);
    end
    repeat (3) @(posedge clk);
    #1 checkBit("rx masked", 1'b0, doorbellIrq_ff);
    regWr(OFS_IRQ_ENABLE, 32'h1);
    waitIrq(); checkBit("rx irq", 1'b1, doorbellIrq_ff);
    for (int i = 0; i < QUEUE_DEPTH; i++) begin
      regRd(OFS_RX_POP); check("rx word", rxWord(msgA[i], idA[i]), rdata);
    end
    regRd(OFS_RX_POP); check("rx overflow", 32'h0, rdata);
    repeat (3) @(posedge clk);
    #1 checkBit("rx irq drained", 1'b0, doorbellIrq_ff);
    // A reset in mid-run empties the queues and clears the enables.
    regWr(OFS_IRQ_ENABLE, 32'h7);
    i_far.sendRx(16'h1234, 16'h5678);
    waitIrq(); checkBit("irq before reset", 1'b1, doorbellIrq_ff);
    @(posedge clk);
    #1 reset = 1;
    repeat (2) @(posedge clk);
    #1 reset = 0;
    checkBit("irq after reset", 1'b0, doorbellIrq_ff);
    regRd(OFS_IRQ_ENABLE); check("enable after reset", 32'h0, rdata);
    regRd(OFS_RX_POP); check("rx after reset", 32'h0, rdata);
    conclude();
  end
endmodule

// ===== testbench/remote_endpoint_model.sv
// Behavioural model of the remote endpoint at the far end of the doorbell link.
`timescale 1ns/1ps
module remote_endpoint_model (
  input wire logic clk, // System clock.
  input wire logic txValid, // Doorbell packet offered by the unit.
  input wire logic [7:0] errPattern, // Per-packet failure pattern chosen by the bench.
  output logic txReady, // Link takes the offer.
  output logic txDone, // Packet finished.
  output logic txError, // Packet finished unsuccessfully.
  output logic rxValid, // Doorbell arriving for the unit.
  output logic [15:0] rxMessage, // Arriving payload.
  output logic [15:0] sender_endpoint_id // Arriving source ID.
);
  int busy = 0; // One packet outstanding.
  int waitN = 0; // Cycles left before completion.
  int k = 0; // Packet count, indexes the failure pattern.
  initial begin
    {txReady, txDone, txError, rxValid, rxMessage, sender_endpoint_id} = '0;
  end
  // ==========================================================================
  // Transmit side: accept with random stall, complete after a random delay.
  // Ready is only raised while an offer stands, so the accept edge is unambiguous.
  always @(posedge clk) begin
    if (txValid && txReady) begin
      busy = 1;
      waitN = $urandom_range(0, 3);
    end
    #1;
    txReady = 0;
    txDone = 0;
    txError = 0;
    if (busy && waitN == 0) begin
      busy = 0;
      txDone = 1;
      txError = errPattern[k % 8];
      k++;
    end else if (busy) begin
      waitN--;
    end else if (txValid) begin
      txReady = ($urandom_range(0, 1) == 1);
    end
  end
  // ==========================================================================
  // Receive side: one doorbell per pulse; lines show the inverse once released.
  task automatic sendRx(logic [15:0] m, logic [15:0] id);
    @(posedge clk);
    #1 rxValid = 1;
    rxMessage = m;
    sender_endpoint_id = id;
    @(posedge clk);
    #1 rxValid = 0;
    rxMessage = ~m;
    sender_endpoint_id = ~id;
  endtask
endmodule

// ===== verilog/doorbell_message_unit.sv
// Doorbell message unit: register slave, transmit, completion and receive queues.
//
// Function
// - Three enable bits gate interrupt sources.
// - Control bit chooses whether failures get recorded.
// - Transmit register write queues message and target.
// - Send one packet per entry; signal completion.
// - Completion register read pops oldest completion.
// - Received doorbell stored; interrupt raised.
// - Receive register read pops oldest message.
// - Received entry carries payload and sender ID.
`timescale 1ns/1ps
module doorbell_message_unit
  import doorbell_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH
) (
  input wire logic clk, // 50 MHz system clock.
  input wire logic reset, // Synchronous active-high reset.
  input wire logic regWrite, // Register write strobe.
  input wire logic regRead, // Register read strobe.
  input wire logic [5:0] regAddr, // Register byte address.
  input wire logic [31:0] regWriteData, // Register write data.
  output logic [31:0] regReadData_ff, // Read data, valid cycle after read.
  output logic regReadValid_ff, // Read data valid pulse.
  output logic txValid_ff, // Outgoing doorbell packet offered.
  output logic [15:0] txMessage_ff, // Outgoing message payload.
  output logic [15:0] target_endpoint_id_ff, // Outgoing destination endpoint ID.
  input wire logic txReady, // Link accepts the offered packet.
  input wire logic txDone, // Outstanding packet finished.
  input wire logic txError, // Outstanding packet finished unsuccessfully.
  input wire logic rxValid, // Received doorbell for this endpoint.
  input wire logic [15:0] rxMessage, // Received message payload.
  input wire logic [15:0] sender_endpoint_id, // Received source endpoint ID.
  output logic doorbellIrq_ff // Doorbell interrupt line.
);
  initial begin
    if (DEPTH < 2) begin
      $error("doorbell_message_unit needs a queue depth of at least 2");
    end
  end

  // ==========================================================================
  // Address decode helper, shared by read and write paths.
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] ofs);
    return addr == ofs;
  endfunction

  // ==========================================================================
  // Control registers.
  logic [2:0] irqEnable_ff; // Per-source interrupt enables.
  logic recordAll_ff; // Record unsuccessful completions too.

  // Software writes to the two control registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      irqEnable_ff <= IRQ_ENABLE_RESET;
      recordAll_ff <= STATUS_CTRL_RESET;
    end else if (regWrite) begin
      if (hit(regAddr, OFS_IRQ_ENABLE)) begin
        irqEnable_ff <= regWriteData[2:0];
      end
      if (hit(regAddr, OFS_TX_STATUS_CTRL)) begin
        recordAll_ff <= regWriteData[0];
      end
    end
  end

  // ==========================================================================
  // Transmit queue: payload in the low half, target ID above.
  logic txPush; // Write to the transmit register.
  logic [31:0] txHead; // Oldest queued doorbell.
  logic txNotEmpty; // Queue holds a doorbell.
  logic txNotFull; // Queue has room.
  logic txPop; // Move head into the sender.

  assign txPush = regWrite && hit(regAddr, OFS_TX_PUSH);

  doorbell_queue #(.WIDTH(32), .DEPTH(DEPTH)) txQueue (
    .clk(clk),
    .reset(reset),
    .push(txPush),
    .pushData(regWriteData),
    .pop(txPop),
    .headData(txHead),
    .notEmpty(txNotEmpty),
    .notFull(txNotFull)
  );

  // ==========================================================================
  // Sender: one packet outstanding at a time, so completions stay in order.
  typedef enum logic [1:0] {SEND_IDLE, SEND_OFFER, SEND_WAIT} send_e;
  send_e sendState_ff;
  logic cplPush; // Record a completion.
  logic [31:0] cplData; // Completion entry.
  logic cplNotFull; // Completion queue has room.

  // The head is taken only when the completion queue can take its result; a
  // full completion queue therefore stalls transmission rather than losing news.
  assign txPop = (sendState_ff == SEND_IDLE) && txNotEmpty && cplNotFull;

  // Offer, then wait for the link's completion of the packet.
  always_ff @(posedge clk) begin
    if (reset) begin
      sendState_ff <= SEND_IDLE;
      txValid_ff <= 1'b0;
      txMessage_ff <= 16'h0000;
      target_endpoint_id_ff <= 16'h0000;
    end else begin
      unique case (sendState_ff)
        SEND_IDLE: begin
          if (txPop) begin
            sendState_ff <= SEND_OFFER;
            txValid_ff <= 1'b1;
            txMessage_ff <= txHead[MSG_LSB +: 16];
            target_endpoint_id_ff <= txHead[ID_LSB +: 16];
          end
        end
        SEND_OFFER: begin
          if (txReady) begin
            sendState_ff <= SEND_WAIT;
            txValid_ff <= 1'b0;
          end
        end
        SEND_WAIT: begin
          if (txDone) begin
            sendState_ff <= SEND_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Completion queue: failures only when recordAll is set.
  assign cplPush = (sendState_ff == SEND_WAIT) && txDone && (!txError || recordAll_ff);
  always_comb begin
    cplData = 32'h0000_0000;
    cplData[MSG_LSB +: 16] = txMessage_ff;
    cplData[ID_LSB +: 14] = target_endpoint_id_ff[13:0];
    cplData[CPL_ERR_BIT] = txError;
    cplData[VALID_BIT] = 1'b1;
  end

  logic cplPop; // Read of the completion register.
  logic [31:0] cplHead; // Oldest completion.
  logic cplNotEmpty; // Completions pending.
  assign cplPop = regRead && hit(regAddr, OFS_CPL_POP);

  doorbell_queue #(.WIDTH(32), .DEPTH(DEPTH)) cplQueue (
    .clk(clk),
    .reset(reset),
    .push(cplPush),
    .pushData(cplData),
    .pop(cplPop),
    .headData(cplHead),
    .notEmpty(cplNotEmpty),
    .notFull(cplNotFull)
  );

  // ==========================================================================
  // Receive queue; overflow drops the newest doorbell.
  logic rxPop; // Read of the receive register.
  logic [31:0] rxHead; // Oldest received doorbell.
  logic rxNotEmpty; // Received doorbells pending.
  assign rxPop = regRead && hit(regAddr, OFS_RX_POP);

  doorbell_queue #(.WIDTH(32), .DEPTH(DEPTH)) rxQueue (
    .clk(clk),
    .reset(reset),
    .push(rxValid),
    .pushData({sender_endpoint_id, rxMessage}),
    .pop(rxPop),
    .headData(rxHead),
    .notEmpty(rxNotEmpty),
    .notFull()
  );

  // ==========================================================================
  // Read data: an empty queue reads zero, so the valid bit is clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      regReadData_ff <= 32'h0000_0000;
      regReadValid_ff <= 1'b0;
    end else begin
      regReadValid_ff <= regRead;
      if (regRead) begin
        regReadData_ff <= 32'h0000_0000;
        if (hit(regAddr, OFS_RX_POP) && rxNotEmpty) begin
          // The whole sender ID is returned, so this word carries no valid bit.
          regReadData_ff <= rxHead;
        end
        if (hit(regAddr, OFS_CPL_POP) && cplNotEmpty) begin
          regReadData_ff <= cplHead;
        end
        if (hit(regAddr, OFS_TX_STATUS_CTRL)) begin
          regReadData_ff[0] <= recordAll_ff;
        end
        if (hit(regAddr, OFS_IRQ_ENABLE)) begin
          regReadData_ff[2:0] <= irqEnable_ff;
        end
        if (hit(regAddr, OFS_TX_PUSH)) begin
          regReadData_ff[0] <= txNotFull;
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt: level while the receive queue holds entries and its source is enabled, or the head completion's kind (success or failure) is enabled.
  logic errPending; // Head completion is a failure.
  logic irqNext; // Next interrupt level.
  assign errPending = cplNotEmpty && cplHead[CPL_ERR_BIT];
  assign irqNext = (irqEnable_ff[IRQ_RX_BIT] && rxNotEmpty)
    || (irqEnable_ff[IRQ_CPL_BIT] && cplNotEmpty && !errPending)
    || (irqEnable_ff[IRQ_ERR_BIT] && errPending);

  always_ff @(posedge clk) begin
    if (reset) begin
      doorbellIrq_ff <= 1'b0;
    end else begin
      doorbellIrq_ff <= irqNext;
    end
  end

  // ==========================================================================
  // Checks.
  a_irq_masked: assert property (@(posedge clk) disable iff (reset)
    (irqEnable_ff == 3'h0 && $past(irqEnable_ff) == 3'h0) |-> !doorbellIrq_ff)
    else $error("Interrupt asserted with all sources disabled");
  a_rx_irq_follows: assert property (@(posedge clk) disable iff (reset)
    (irqEnable_ff[IRQ_RX_BIT] && rxNotEmpty) |=> doorbellIrq_ff)
    else $error("Interrupt missing while received doorbell pending");
  a_irq_drained: assert property (@(posedge clk) disable iff (reset)
    (!rxNotEmpty && !cplNotEmpty) |=> !doorbellIrq_ff)
    else $error("Interrupt held with nothing pending");
  a_tx_offer_hold: assert property (@(posedge clk) disable iff (reset)
    (txValid_ff && !txReady) |=> (txValid_ff && $stable(txMessage_ff)))
    else $error("Offered packet dropped before acceptance");
  a_tx_one_per_entry: assert property (@(posedge clk) disable iff (reset)
    txPop |=> (txValid_ff && txMessage_ff == $past(txHead[15:0])))
    else $error("Queued doorbell not offered next cycle");
  a_tx_push_lands: assert property (@(posedge clk) disable iff (reset)
    (txPush && !txNotEmpty && txNotFull && sendState_ff != SEND_IDLE) |=> txNotEmpty)
    else $error("Transmit write did not queue an entry");
  a_fail_filter: assert property (@(posedge clk) disable iff (reset)
    (sendState_ff == SEND_WAIT && txDone && txError && !recordAll_ff && !cplNotEmpty)
    |=> !cplNotEmpty)
    else $error("Failure recorded while only successes requested");
  a_fail_kept: assert property (@(posedge clk) disable iff (reset)
    (sendState_ff == SEND_WAIT && txDone && recordAll_ff && !cplNotEmpty) |=> cplNotEmpty)
    else $error("Completion not recorded while all are requested");
  a_cpl_read: assert property (@(posedge clk) disable iff (reset)
    (cplPop && cplNotEmpty) |=> (regReadValid_ff && regReadData_ff == $past(cplHead)))
    else $error("Completion read returned wrong entry");
  a_rx_read: assert property (@(posedge clk) disable iff (reset)
    (rxPop && rxNotEmpty) |=> (regReadValid_ff && regReadData_ff == $past(rxHead)))
    else $error("Receive read returned wrong entry");
  a_cpl_irq: assert property (@(posedge clk) disable iff (reset)
    (irqEnable_ff[IRQ_CPL_BIT] && cplNotEmpty && !cplHead[CPL_ERR_BIT]) |=> doorbellIrq_ff)
    else $error("Interrupt missing while completion pending");
  a_err_irq: assert property (@(posedge clk) disable iff (reset)
    (irqEnable_ff[IRQ_ERR_BIT] && cplNotEmpty && cplHead[CPL_ERR_BIT]) |=> doorbellIrq_ff)
    else $error("Interrupt missing while failed completion pending");
endmodule

// ===== verilog/doorbell_pkg.sv
// Package of register offsets, field layouts and reset values for the doorbell unit.
package doorbell_pkg;
  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [5:0] OFS_RX_POP = 6'h00;
  localparam logic [5:0] OFS_TX_PUSH = 6'h0C;
  localparam logic [5:0] OFS_CPL_POP = 6'h14;
  localparam logic [5:0] OFS_TX_STATUS_CTRL = 6'h1C;
  localparam logic [5:0] OFS_IRQ_ENABLE = 6'h20;
  // ==========================================================================
  // Field layout: message in the low half, endpoint ID above it.
  localparam int MSG_LSB = 0;
  localparam int ID_LSB = 16;
  localparam int VALID_BIT = 31;
  localparam int CPL_ERR_BIT = 30;
  // Interrupt enable bits: received, completed, and completion error.
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_CPL_BIT = 1;
  localparam int IRQ_ERR_BIT = 2;
  localparam logic [2:0] IRQ_ENABLE_RESET = 3'h0;
  localparam logic STATUS_CTRL_RESET = 1'b0;
  // ==========================================================================
  // Default queue depth.
  localparam int QUEUE_DEPTH = 8;
endpackage

// ===== verilog/doorbell_queue.sv
// Small flip-flop FIFO used for transmit, completion and receive doorbell queues.
`timescale 1ns/1ps
module doorbell_queue
  import doorbell_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Synchronous active-high reset.
  input wire logic push, // Write one entry.
  input wire logic [WIDTH-1:0] pushData, // Entry to write.
  input wire logic pop, // Remove the oldest entry.
  output logic [WIDTH-1:0] headData, // Oldest entry.
  output logic notEmpty, // At least one entry held.
  output logic notFull // Room for another entry.
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("doorbell_queue depth must be a power of two of at least 2");
    end
  end

  // ==========================================================================
  // Storage and pointers; one extra pointer bit tells full from empty.
  logic [WIDTH-1:0] mem_ff [DEPTH]; // Entry storage.
  logic [AW:0] wrPtr_ff; // Write pointer.
  logic [AW:0] rdPtr_ff; // Read pointer.
  logic doPush; // Accepted push.
  logic doPop; // Accepted pop.

  assign notEmpty = (wrPtr_ff != rdPtr_ff);
  assign notFull = (wrPtr_ff[AW-1:0] != rdPtr_ff[AW-1:0]) || (wrPtr_ff[AW] == rdPtr_ff[AW]);
  assign doPush = push && notFull;
  assign doPop = pop && notEmpty;
  assign headData = mem_ff[rdPtr_ff[AW-1:0]];

  // Store accepted entries; a push into a full queue is dropped.
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_ff[wrPtr_ff[AW-1:0]] <= pushData;
    end
  end

  // Advance the pointers.
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end
endmodule
